// ==== hdl/rnf_pkg.sv ====
// constants shared by the request node filter files
// Behaviour
// [R1] lower async filter bit n accepts requests from local node n, 0 to 31
// [R2] lower async filter has set port 108h, clear port 10Ch, both read the value
// [R3] both filter registers come out of reset as all zeros
// [R4] upper physical filter bit k routes local node k+32 to the physical context
// [R5] physical-bound packets pass the async check first, then the physical check
// [R6] physical filter bit clear sends the request to the async receive context
// [R7] per-node lookup only for local-bus sources; others use the all-buses bit
// [R8] non-local packets are not acknowledged unless physical filter bit 31 is set; the code also acknowledges them when upper async filter bit 31 is set
// [R9] physical filter bit 31 set accepts all requests from non-local buses
// [R10] physical filter bit 31 survives the physical-layer reset input
// [R11] upper physical filter has set port 110h, clear port 114h, both read the value
// [R12] local request with its async filter bit clear is not acknowledged nor queued
// [R13] upper async filter covers nodes 32 to 62, its bit 31 accepts non-local
// [R14] lower physical filter covers nodes 0 to 31 for the physical check
// [R15] software writes ones to set or clear bits; zero bits change nothing
// [R16] filter bits are judged when the source node is known, before the decision
package rnf_pkg;
    // -----------------------------------------------------------------
    // register map, byte addresses
    // -----------------------------------------------------------------
    localparam logic [11:0] OFF_ASYNC_LOW_SET = 12'h108;
    localparam logic [11:0] OFF_ASYNC_LOW_CLR = 12'h10C;
    localparam logic [11:0] OFF_PHYS_HIGH_SET = 12'h110;
    localparam logic [11:0] OFF_PHYS_HIGH_CLR = 12'h114;
    // -----------------------------------------------------------------
    // register contents
    // -----------------------------------------------------------------
    localparam int FILTER_W = 32;
    localparam logic [31:0] FILTER_RESET = 32'h00000000;
    localparam int ALL_BUSES_BIT = 31;
    // bits kept through the physical-layer reset
    localparam logic [31:0] PHYS_KEEP_MASK = 32'h80000000;
    localparam logic [31:0] NO_KEEP_MASK = 32'h00000000;
    localparam int NODE_W = 6;
    localparam logic [5:0] NODE_UPPER_BASE = 6'h20;
    localparam logic [5:0] NODE_BROADCAST = 6'h3F;
    // -----------------------------------------------------------------
    // decoded register selects and bus answers
    // -----------------------------------------------------------------
    typedef enum logic [2:0] {
        RNF_SEL_NONE,
        RNF_SEL_LOW_SET,
        RNF_SEL_LOW_CLR,
        RNF_SEL_HIGH_SET,
        RNF_SEL_HIGH_CLR
    } rnf_sel_t;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ==== hdl/rnf_setclr_reg.sv ====
// one set/clear filter register with a partial wipe
`timescale 1ns/10ps
module rnf_setclr_reg #(
    parameter int WIDTH = 32,
    parameter logic [WIDTH-1:0] RESET_VAL = '0,
    parameter logic [WIDTH-1:0] KEEP_MASK = '0
) (
    input wire logic sys_clk_i,
    input wire logic reset_i,
    input wire logic wipe_i,
    input wire logic [WIDTH-1:0] set_i,
    input wire logic [WIDTH-1:0] clr_i,
    output logic [WIDTH-1:0] value_o
);
    logic [WIDTH-1:0] value_reg;
    logic [WIDTH-1:0] value_next;

    // -----------------------------------------------------------------
    // next value
    // -----------------------------------------------------------------
    // set wins over a wipe in the same cycle, so a write is never lost
    always_comb
    begin
        value_next = value_reg;
        if (wipe_i)
        begin
            value_next = value_next & KEEP_MASK; // R10
        end
        value_next = (value_next & ~clr_i) | set_i; // R15
    end

    // storage
    always_ff @(posedge sys_clk_i)
    begin
        if (reset_i)
        begin
            value_reg <= RESET_VAL; // R3
        end
        else
        begin
            value_reg <= value_next;
        end
    end

    assign value_o = value_reg;
endmodule

// ==== hdl/rnf_node_lookup.sv ====
// per-node accept and routing decision for one incoming request
`timescale 1ns/10ps
module rnf_node_lookup (
    input wire logic [31:0] async_low_i,
    input wire logic [31:0] async_high_i,
    input wire logic [31:0] phys_low_i,
    input wire logic [31:0] phys_high_i,
    input wire logic [5:0] src_node_i,
    input wire logic src_local_i,
    input wire logic to_phys_i,
    output logic accept_o,
    output logic to_phys_o,
    output logic to_arrq_o
);
    logic [63:0] async_map;
    logic [63:0] phys_map;
    logic async_ok;
    logic phys_ok;

    // node 63 is broadcast and owns no bit: the top bit is the all-buses flag
    function automatic logic node_bit(input logic [63:0] map, input logic [5:0] node);
        node_bit = (node == rnf_pkg::NODE_BROADCAST) ? 1'b0 : map[node];
    endfunction

    // -----------------------------------------------------------------
    // node maps, lower register first
    // -----------------------------------------------------------------
    assign async_map = {async_high_i, async_low_i}; // R1 R13
    assign phys_map = {phys_high_i, phys_low_i}; // R4 R14

    // first stage async check, then second stage physical check
    always_comb
    begin
        if (src_local_i)
        begin
            async_ok = node_bit(async_map, src_node_i); // R1 R12 R7
            phys_ok = node_bit(phys_map, src_node_i); // R4 R14
        end
        else
        begin
            // R7 R8 R9 R13
            async_ok = async_high_i[rnf_pkg::ALL_BUSES_BIT] | phys_high_i[rnf_pkg::ALL_BUSES_BIT];
            phys_ok = phys_high_i[rnf_pkg::ALL_BUSES_BIT];
        end
    end

    // routing only for accepted requests
    assign accept_o = async_ok; // R12
    assign to_phys_o = async_ok & to_phys_i & phys_ok; // R5
    assign to_arrq_o = async_ok & ~(to_phys_i & phys_ok); // R6
endmodule

// ==== hdl/rnf_request_filter.sv ====
// request node filter top: AXI4-Lite slave, two filter registers, request decision
`timescale 1ns/10ps
module rnf_request_filter #(
    parameter int ADDR_W = 12
) (
    input wire logic sys_clk_i,
    input wire logic reset_i,
    input wire logic phy_layer_reset_input_i,
    input wire logic [ADDR_W-1:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic [ADDR_W-1:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    input wire logic [31:0] async_filter_high_i,
    input wire logic [31:0] phys_filter_low_i,
    input wire logic req_valid_i,
    input wire logic [5:0] req_src_node_i,
    input wire logic req_src_local_i,
    input wire logic req_to_phys_i,
    output logic dec_valid_o,
    output logic dec_ack_o,
    output logic dec_to_phys_o,
    output logic dec_to_arrq_o
);
    // -----------------------------------------------------------------
    // declarations
    // -----------------------------------------------------------------
    logic [ADDR_W-1:0] aw_addr_reg;
    logic aw_held_reg;
    logic [31:0] w_data_reg;
    logic [3:0] w_strb_reg;
    logic w_held_reg;
    logic bvalid_reg;
    logic [1:0] bresp_reg;
    logic rvalid_reg;
    logic [31:0] rdata_reg;
    logic [1:0] rresp_reg;
    logic wr_fire;
    rnf_pkg::rnf_sel_t wr_sel;
    rnf_pkg::rnf_sel_t rd_sel;
    logic [31:0] lane_mask;
    logic [31:0] wr_bits;
    logic [31:0] low_set;
    logic [31:0] low_clr;
    logic [31:0] high_set;
    logic [31:0] high_clr;
    logic [31:0] async_low;
    logic [31:0] phys_high;
    logic lk_accept;
    logic lk_to_phys;
    logic lk_to_arrq;
    logic dec_valid_reg;
    logic dec_ack_reg;
    logic dec_to_phys_reg;
    logic dec_to_arrq_reg;

    // offset decode, shared by the write and the read path
    function automatic rnf_pkg::rnf_sel_t reg_decode(input logic [ADDR_W-1:0] addr);
        logic [11:0] a;
        a = {addr[11:2], 2'b00};
        case (a)
            rnf_pkg::OFF_ASYNC_LOW_SET: reg_decode = rnf_pkg::RNF_SEL_LOW_SET; // R2
            rnf_pkg::OFF_ASYNC_LOW_CLR: reg_decode = rnf_pkg::RNF_SEL_LOW_CLR; // R2
            rnf_pkg::OFF_PHYS_HIGH_SET: reg_decode = rnf_pkg::RNF_SEL_HIGH_SET; // R11
            rnf_pkg::OFF_PHYS_HIGH_CLR: reg_decode = rnf_pkg::RNF_SEL_HIGH_CLR; // R11
            default: reg_decode = rnf_pkg::RNF_SEL_NONE;
        endcase
    endfunction

    // -----------------------------------------------------------------
    // write channels
    // -----------------------------------------------------------------
    // address and data are caught separately, in either order
    assign s_axi_awready_o = ~aw_held_reg;
    assign s_axi_wready_o = ~w_held_reg;
    assign wr_fire = aw_held_reg & w_held_reg & ~bvalid_reg;

    // write address holding
    always_ff @(posedge sys_clk_i)
    begin
        if (reset_i)
        begin
            aw_held_reg <= 1'b0;
            aw_addr_reg <= '0;
        end
        else if (s_axi_awvalid_i && !aw_held_reg)
        begin
            aw_held_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr_i;
        end
        else if (wr_fire)
        begin
            aw_held_reg <= 1'b0;
        end
    end

    // write data holding
    always_ff @(posedge sys_clk_i)
    begin
        if (reset_i)
        begin
            w_held_reg <= 1'b0;
            w_data_reg <= '0;
            w_strb_reg <= '0;
        end
        else if (s_axi_wvalid_i && !w_held_reg)
        begin
            w_held_reg <= 1'b1;
            w_data_reg <= s_axi_wdata_i;
            w_strb_reg <= s_axi_wstrb_i;
        end
        else if (wr_fire)
        begin
            w_held_reg <= 1'b0;
        end
    end

    // write response; an unmapped offset changes nothing and answers an error
    always_ff @(posedge sys_clk_i)
    begin
        if (reset_i)
        begin
            bvalid_reg <= 1'b0;
            bresp_reg <= rnf_pkg::RESP_OKAY;
        end
        else if (wr_fire)
        begin
            bvalid_reg <= 1'b1;
            bresp_reg <= (wr_sel == rnf_pkg::RNF_SEL_NONE) ? rnf_pkg::RESP_SLVERR : rnf_pkg::RESP_OKAY;
        end
        else if (s_axi_bready_i)
        begin
            bvalid_reg <= 1'b0;
        end
    end

    assign s_axi_bvalid_o = bvalid_reg;
    assign s_axi_bresp_o = bresp_reg;

    // -----------------------------------------------------------------
    // set and clear strobes
    // -----------------------------------------------------------------
    // byte lanes without a strobe leave their bits untouched
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++)
        begin : g_lane
            assign lane_mask[gi*8 +: 8] = {8{w_strb_reg[gi]}};
        end
    endgenerate

    assign wr_sel = reg_decode(aw_addr_reg);
    assign wr_bits = w_data_reg & lane_mask; // R15
    assign low_set = (wr_fire && wr_sel == rnf_pkg::RNF_SEL_LOW_SET) ? wr_bits : '0; // R2
    assign low_clr = (wr_fire && wr_sel == rnf_pkg::RNF_SEL_LOW_CLR) ? wr_bits : '0; // R2
    assign high_set = (wr_fire && wr_sel == rnf_pkg::RNF_SEL_HIGH_SET) ? wr_bits : '0; // R11
    assign high_clr = (wr_fire && wr_sel == rnf_pkg::RNF_SEL_HIGH_CLR) ? wr_bits : '0; // R11

    // lower async filter is untouched by the physical-layer reset
    rnf_setclr_reg #(
        .WIDTH(rnf_pkg::FILTER_W),
        .RESET_VAL(rnf_pkg::FILTER_RESET),
        .KEEP_MASK(rnf_pkg::NO_KEEP_MASK)
    ) u_async_low (
        .sys_clk_i(sys_clk_i),
        .reset_i(reset_i),
        .wipe_i(1'b0),
        .set_i(low_set),
        .clr_i(low_clr),
        .value_o(async_low)
    );

    // upper physical filter: per-node bits wiped, all-buses bit kept
    rnf_setclr_reg #(
        .WIDTH(rnf_pkg::FILTER_W),
        .RESET_VAL(rnf_pkg::FILTER_RESET),
        .KEEP_MASK(rnf_pkg::PHYS_KEEP_MASK)
    ) u_phys_high (
        .sys_clk_i(sys_clk_i),
        .reset_i(reset_i),
        .wipe_i(phy_layer_reset_input_i),
        .set_i(high_set),
        .clr_i(high_clr),
        .value_o(phys_high)
    );

    // -----------------------------------------------------------------
    // read channel
    // -----------------------------------------------------------------
    assign s_axi_arready_o = ~rvalid_reg;
    assign rd_sel = reg_decode(s_axi_araddr_i);

    // set and clear ports both return the live value
    always_ff @(posedge sys_clk_i)
    begin
        if (reset_i)
        begin
            rvalid_reg <= 1'b0;
            rdata_reg <= '0;
            rresp_reg <= rnf_pkg::RESP_OKAY;
        end
        else if (s_axi_arvalid_i && !rvalid_reg)
        begin
            rvalid_reg <= 1'b1;
            rresp_reg <= rnf_pkg::RESP_OKAY;
            case (rd_sel)
                rnf_pkg::RNF_SEL_LOW_SET, rnf_pkg::RNF_SEL_LOW_CLR: rdata_reg <= async_low; // R2
                rnf_pkg::RNF_SEL_HIGH_SET, rnf_pkg::RNF_SEL_HIGH_CLR: rdata_reg <= phys_high; // R11
                default:
                begin
                    rdata_reg <= '0;
                    rresp_reg <= rnf_pkg::RESP_SLVERR;
                end
            endcase
        end
        else if (s_axi_rready_i)
        begin
            rvalid_reg <= 1'b0;
        end
    end

    assign s_axi_rvalid_o = rvalid_reg;
    assign s_axi_rdata_o = rdata_reg;
    assign s_axi_rresp_o = rresp_reg;

    // -----------------------------------------------------------------
    // request decision
    // -----------------------------------------------------------------
    rnf_node_lookup u_lookup (
        .async_low_i(async_low),
        .async_high_i(async_filter_high_i),
        .phys_low_i(phys_filter_low_i),
        .phys_high_i(phys_high),
        .src_node_i(req_src_node_i),
        .src_local_i(req_src_local_i),
        .to_phys_i(req_to_phys_i),
        .accept_o(lk_accept),
        .to_phys_o(lk_to_phys),
        .to_arrq_o(lk_to_arrq)
    );

    // judged on the filter value in the cycle the node is presented
    always_ff @(posedge sys_clk_i)
    begin
        if (reset_i)
        begin
            dec_valid_reg <= 1'b0;
            dec_ack_reg <= 1'b0;
            dec_to_phys_reg <= 1'b0;
            dec_to_arrq_reg <= 1'b0;
        end
        else
        begin
            dec_valid_reg <= req_valid_i; // R16
            dec_ack_reg <= req_valid_i & lk_accept; // R12
            dec_to_phys_reg <= req_valid_i & lk_to_phys; // R5
            dec_to_arrq_reg <= req_valid_i & lk_to_arrq; // R6
        end
    end

    assign dec_valid_o = dec_valid_reg;
    assign dec_ack_o = dec_ack_reg;
    assign dec_to_phys_o = dec_to_phys_reg;
    assign dec_to_arrq_o = dec_to_arrq_reg;

    // -----------------------------------------------------------------
    // assertions
    // -----------------------------------------------------------------
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (reset_i);

    sequence s_local_low;
        req_valid_i && req_src_local_i && req_src_node_i < rnf_pkg::NODE_UPPER_BASE;
    endsequence

    sequence s_local_high_phys;
        req_valid_i && req_src_local_i && req_to_phys_i && req_src_node_i >= rnf_pkg::NODE_UPPER_BASE
            && req_src_node_i != rnf_pkg::NODE_BROADCAST;
    endsequence

    sequence s_remote;
        req_valid_i && !req_src_local_i;
    endsequence

    chk_low_accept: assert property (s_local_low ##0 async_low[req_src_node_i[4:0]] |=> dec_ack_o) // R1
        else $error("local node with its bit set was not accepted");
    chk_local_deny: assert property (s_local_low ##0 !async_low[req_src_node_i[4:0]]
        |=> dec_valid_o && !dec_ack_o && !dec_to_phys_o && !dec_to_arrq_o) // R12
        else $error("local node with its bit clear was accepted");
    chk_phys_route: assert property (s_local_high_phys ##0 async_filter_high_i[req_src_node_i[4:0]]
        ##0 phys_high[req_src_node_i[4:0]] |=> dec_to_phys_o && !dec_to_arrq_o) // R4
        else $error("upper node was not routed to the physical context");
    chk_phys_fallback: assert property (s_local_high_phys ##0 async_filter_high_i[req_src_node_i[4:0]]
        ##0 !phys_high[req_src_node_i[4:0]] |=> dec_to_arrq_o && !dec_to_phys_o) // R6
        else $error("request with physical bit clear not sent to async context");
    chk_two_stage: assert property (dec_to_phys_o |-> dec_ack_o && !dec_to_arrq_o) // R5
        else $error("physical routing without passing the async check");
    chk_remote_deny: assert property (s_remote ##0 !phys_high[rnf_pkg::ALL_BUSES_BIT]
        ##0 !async_filter_high_i[rnf_pkg::ALL_BUSES_BIT] |=> !dec_ack_o) // R8
        else $error("non-local packet acknowledged without the all-buses bit");
    chk_remote_accept: assert property (s_remote ##0 phys_high[rnf_pkg::ALL_BUSES_BIT] |=> dec_ack_o) // R9
        else $error("non-local packet refused with the all-buses bit set");
    chk_allbus_keep: assert property (phy_layer_reset_input_i && !wr_fire
        |=> phys_high[rnf_pkg::ALL_BUSES_BIT] == $past(phys_high[rnf_pkg::ALL_BUSES_BIT])
            && phys_high[30:0] == 31'h00000000) // R10
        else $error("physical-layer reset disturbed the all-buses bit");
    chk_reset_zero: assert property ($fell(reset_i) |-> async_low == rnf_pkg::FILTER_RESET
        && phys_high == rnf_pkg::FILTER_RESET) // R3
        else $error("filter registers not zero after reset");
    chk_set_port: assert property (wr_fire && wr_sel == rnf_pkg::RNF_SEL_LOW_SET
        |=> async_low == ($past(async_low) | $past(wr_bits))) // R2
        else $error("set port did not set exactly the written ones");
    chk_clear_port: assert property (wr_fire && wr_sel == rnf_pkg::RNF_SEL_HIGH_CLR && !phy_layer_reset_input_i
        |=> phys_high == ($past(phys_high) & ~$past(wr_bits))) // R11
        else $error("clear port did not clear exactly the written ones");
    chk_read_back: assert property (s_axi_arvalid_i && !rvalid_reg && rd_sel == rnf_pkg::RNF_SEL_LOW_CLR
        |=> s_axi_rvalid_o && s_axi_rdata_o == $past(async_low)) // R2
        else $error("clear port read did not return the filter value");
    chk_write_answer: assert property (wr_fire |=> s_axi_bvalid_o) // R15
        else $error("write response missing after the write");
endmodule

// ==== testbench/rnf_link_rx_model.sv ====
// link receive path model that hands source node requests to the filter
`timescale 1ns/10ps
module rnf_link_rx_model (
    input wire logic sys_clk_i,
    output logic req_valid_o,
    output logic [5:0] req_src_node_o,
    output logic req_src_local_o,
    output logic req_to_phys_o
);
    // -----------------------------------------------------------------
    // idle lines
    // -----------------------------------------------------------------
    initial
    begin
        req_valid_o = 1'b0;
        req_src_node_o = 6'h00;
        req_src_local_o = 1'b0;
        req_to_phys_o = 1'b0;
    end
    // -----------------------------------------------------------------
    // one request per call
    // -----------------------------------------------------------------
    // fields are inverted after the pulse so a stale node never looks valid
    task automatic send(input logic [5:0] node, input logic loc, input logic phys);
        @(posedge sys_clk_i);
        req_valid_o <= 1'b1;
        req_src_node_o <= node;
        req_src_local_o <= loc;
        req_to_phys_o <= phys;
        @(posedge sys_clk_i);
        req_valid_o <= 1'b0;
        req_src_node_o <= ~node;
        req_src_local_o <= ~loc;
        req_to_phys_o <= ~phys;
        #1;
    endtask
endmodule

// ==== testbench/test_ieee1394_request_node_filter.sv ====
// testbench for the request node filter: register access and request decisions
`timescale 1ns/10ps
module test_ieee1394_request_node_filter;
    logic sys_clk, reset, phy_rst, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, req_valid, req_local, req_phys;
    logic dec_valid, dec_ack, dec_phys, dec_arrq;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata, async_hi, phys_lo, m_low, m_high;
    logic [1:0] bresp, rresp;
    logic [5:0] req_node;
    int failures, check_count, i;
    // -----------------------------------------------------------------
    // design and link model
    // -----------------------------------------------------------------
    rnf_request_filter #(.ADDR_W(12)) u_rnf_request_filter (.sys_clk_i(sys_clk), .reset_i(reset),
        .phy_layer_reset_input_i(phy_rst), .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
        .s_axi_awready_o(awready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wvalid),
        .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
        .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
        .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
        .async_filter_high_i(async_hi), .phys_filter_low_i(phys_lo), .req_valid_i(req_valid),
        .req_src_node_i(req_node), .req_src_local_i(req_local), .req_to_phys_i(req_phys),
        .dec_valid_o(dec_valid), .dec_ack_o(dec_ack), .dec_to_phys_o(dec_phys), .dec_to_arrq_o(dec_arrq));
    rnf_link_rx_model u_rnf_link_rx_model (.sys_clk_i(sys_clk), .req_valid_o(req_valid),
        .req_src_node_o(req_node), .req_src_local_o(req_local), .req_to_phys_o(req_phys));
    // 40 MHz clock
    initial
    begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    // -----------------------------------------------------------------
    // reporting
    // -----------------------------------------------------------------
    task automatic summarize();
        if (failures == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk_val(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp)
        begin
            failures++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chk_dec(input logic [3:0] exp, input logic [3:0] got);
        check_count++;
        if (got !== exp)
        begin
            failures++;
            $display("ERROR decision valid_ack_phys_arrq expected %b seen %b", exp, got);
        end
    endtask
    // -----------------------------------------------------------------
    // bus tasks; the model registers follow only accepted writes
    // -----------------------------------------------------------------
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        logic [1:0] r;
        @(posedge sys_clk);
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= d;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 20; n++)
        begin
            @(posedge sys_clk);
            if (awvalid && awready)
                awvalid <= 1'b0;
            if (wvalid && wready)
                wvalid <= 1'b0;
            if (bvalid === 1'b1)
            begin
                r = bresp;
                bready <= 1'b0;
                break;
            end
        end
        if (n == 20)
        begin
            failures++;
            summarize();
        end
        chk_val("bresp", {30'h0, er}, {30'h0, r});
        if (er == rnf_pkg::RESP_OKAY && a == rnf_pkg::OFF_ASYNC_LOW_SET)
            m_low = m_low | d;
        if (er == rnf_pkg::RESP_OKAY && a == rnf_pkg::OFF_ASYNC_LOW_CLR)
            m_low = m_low & ~d;
        if (er == rnf_pkg::RESP_OKAY && a == rnf_pkg::OFF_PHYS_HIGH_SET)
            m_high = m_high | d;
        if (er == rnf_pkg::RESP_OKAY && a == rnf_pkg::OFF_PHYS_HIGH_CLR)
            m_high = m_high & ~d;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic [1:0] er);
        int n;
        logic [31:0] d;
        logic [1:0] r;
        @(posedge sys_clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 20; n++)
        begin
            @(posedge sys_clk);
            if (arvalid && arready)
                arvalid <= 1'b0;
            if (rvalid === 1'b1)
            begin
                d = rdata;
                r = rresp;
                rready <= 1'b0;
                break;
            end
        end
        if (n == 20)
        begin
            failures++;
            summarize();
        end
        chk_val("rdata", exp, d);
        chk_val("rresp", {30'h0, er}, {30'h0, r});
    endtask
    // expected accept and routing from the filter values in force
    function automatic logic [2:0] exp_dec(input logic [5:0] n, input logic loc, input logic tp);
        logic acc, pok;
        logic [63:0] af, pf;
        af = {async_hi, m_low};
        pf = {m_high, phys_lo};
        acc = loc ? (n != 6'h3F && af[n]) : (async_hi[31] | m_high[31]);
        pok = loc ? pf[n] : m_high[31];
        return {acc, acc & tp & pok, acc & ~(tp & pok)};
    endfunction
    task automatic req(input logic [5:0] n, input logic loc, input logic tp);
        logic [2:0] e;
        // expectation taken once the inputs seen at the request edge have settled
        u_rnf_link_rx_model.send(n, loc, tp);
        e = exp_dec(n, loc, tp);
        chk_dec({1'b1, e}, {dec_valid, dec_ack, dec_phys, dec_arrq});
    endtask
    // -----------------------------------------------------------------
    // main sequence
    // -----------------------------------------------------------------
    initial
    begin
        reset = 1'b1;
        {awvalid, wvalid, bready, arvalid, rready, phy_rst} = 6'h00;
        {awaddr, araddr, wdata, async_hi, phys_lo, m_low, m_high} = '0;
        failures = 0;
        check_count = 0;
        repeat (3) @(posedge sys_clk);
        reset <= 1'b0;
        for (i = 0; i < 4; i++)
            rd(12'h108 + 12'(4 * i), 32'h00000000, rnf_pkg::RESP_OKAY);
        wr(rnf_pkg::OFF_ASYNC_LOW_SET, 32'h80000005, rnf_pkg::RESP_OKAY);
        rd(rnf_pkg::OFF_ASYNC_LOW_CLR, m_low, rnf_pkg::RESP_OKAY);
        wr(rnf_pkg::OFF_ASYNC_LOW_CLR, 32'h00000004, rnf_pkg::RESP_OKAY);
        rd(rnf_pkg::OFF_ASYNC_LOW_SET, m_low, rnf_pkg::RESP_OKAY);
        wr(rnf_pkg::OFF_PHYS_HIGH_SET, 32'h40000001, rnf_pkg::RESP_OKAY);
        rd(rnf_pkg::OFF_PHYS_HIGH_CLR, m_high, rnf_pkg::RESP_OKAY);
        // companion filters: nodes 32, 33, 62 accepted, node 0 physical
        @(posedge sys_clk);
        async_hi <= 32'h40000003;
        phys_lo <= 32'h00000001;
        for (i = 0; i < 128; i++)
            req(i[5:0], 1'b1, i[6]);
        req(6'h22, 1'b0, 1'b1);
        @(posedge sys_clk);
        async_hi <= 32'hC0000003;
        req(6'h22, 1'b0, 1'b1);
        @(posedge sys_clk);
        async_hi <= 32'h40000003;
        wr(rnf_pkg::OFF_PHYS_HIGH_SET, 32'h80000000, rnf_pkg::RESP_OKAY);
        req(6'h22, 1'b0, 1'b1);
        req(6'h22, 1'b0, 1'b0);
        // phy-layer reset keeps only the all-buses bit of the upper physical filter; the lower async filter is left whole
        @(posedge sys_clk);
        phy_rst <= 1'b1;
        @(posedge sys_clk);
        phy_rst <= 1'b0;
        m_high = m_high & 32'h80000000;
        rd(rnf_pkg::OFF_PHYS_HIGH_SET, m_high, rnf_pkg::RESP_OKAY);
        rd(rnf_pkg::OFF_ASYNC_LOW_SET, m_low, rnf_pkg::RESP_OKAY);
        rd(12'h118, 32'h00000000, rnf_pkg::RESP_SLVERR);
        wr(12'h118, 32'hFFFFFFFF, rnf_pkg::RESP_SLVERR);
        rd(rnf_pkg::OFF_PHYS_HIGH_CLR, m_high, rnf_pkg::RESP_OKAY);
        summarize();
    end
endmodule
